// ===== spl_regs.svh
`ifndef SPL_REGS_SVH
`define SPL_REGS_SVH

// register indices; the byte address is four times the index
`define SPL_IDX_BASIC_CTRL 5'h00
`define SPL_IDX_ADVERT 5'h04
`define SPL_IDX_PHY_CTRL 5'h16
`define SPL_IDX_STRAP_STAT 5'h1F

// basic control field positions
`define SPL_BC_SPEED 13
`define SPL_BC_AUTONEG 12
`define SPL_BC_ISOLATE 10
`define SPL_BC_DUPLEX 8

// advertisement field positions and values
`define SPL_AD_ABIL_LO 5
`define SPL_AD_ABIL_HI 8
`define SPL_AD_ABIL_100 4'hF
`define SPL_AD_ABIL_10 4'h3
`define SPL_AD_SELECTOR 5'h01

// phy control field positions
`define SPL_PC_WAKE_EN 15
`define SPL_PC_ADDR0_UNIQUE 9

// strap vector layout, also the strap status layout
`define SPL_NUM_STRAPS 13
`define SPL_ST_ADDR_LO 0
`define SPL_ST_MODE_LO 3
`define SPL_ST_WAKE 6
`define SPL_ST_ISOLATE 7
`define SPL_ST_SPEED 8
`define SPL_ST_DUPLEX 9
`define SPL_ST_AUTONEG 10
`define SPL_ST_ADDR0_UNIQUE 11
`define SPL_ST_CHAIN_N 12
`define SPL_ST_VALID 15

// internal pull direction per strap and the value an unstrapped board gives
`define SPL_STRAP_PULL_UP 13'h1701
`define SPL_STRAP_DEFAULT 13'h1701

// interface mode patterns and fixed address bits
`define SPL_MODE_NORMAL 3'h0
`define SPL_MODE_B2B 3'h6
`define SPL_MGMT_UPPER 2'h0

`endif

// ===== spl_pkg.sv
`include "spl_regs.svh"

package spl_pkg;

	// strap pins, packed in the strap status layout
	typedef struct packed {
		logic chain_test_n;
		logic address_zero_unique_strap;
		logic autoneg_enable_strap;
		logic duplex;
		logic speed;
		logic isolate;
		logic wake_output_enable_strap;
		logic [2:0] mode;
		logic [2:0] mgmt_address_strap;
	} spl_straps_t;

	// decoded interface mode
	typedef enum logic [1:0] {
		SPL_IF_NORMAL = 2'b00,
		SPL_IF_B2B = 2'b01,
		SPL_IF_RESERVED = 2'b10
	} spl_if_mode_t;

	// bus answer sequencer
	typedef enum logic {
		SPL_BUS_IDLE = 1'b0,
		SPL_BUS_ANSWER = 1'b1
	} spl_bus_state_t;

endpackage

// ===== spl_strap_capture.sv
`timescale 1ns/1ps

module spl_strap_capture #(
	parameter int WIDTH = 13,
	parameter logic [WIDTH-1:0] DEFAULT = '0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// capture control
	input wire logic release_pulse,
	input wire logic [WIDTH-1:0] pins_in,
	// held result
	output logic [WIDTH-1:0] captured,
	output logic valid
);

	initial
	begin
		if (WIDTH < 1)
			$error("strap width must be at least one");
	end

	// value stays put between releases, so a pin turned output cannot disturb it
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			captured <= DEFAULT;
		else if (release_pulse)
			captured <= pins_in;
	end

	// marks that a real capture happened since the async reset
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			valid <= 1'b0;
		else if (release_pulse)
			valid <= 1'b1;
	end

endmodule

// ===== spl_pad_bank.sv
`timescale 1ns/1ps

module spl_pad_bank #(
	parameter int WIDTH = 13,
	parameter logic [WIDTH-1:0] PULL_UP = '0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// phase and functional data
	input wire logic drive_en,
	input wire logic [WIDTH-1:0] func_out,
	// pad side
	output logic [WIDTH-1:0] pad_o,
	output logic [WIDTH-1:0] pad_oe,
	output logic [WIDTH-1:0] pull_up_en,
	output logic [WIDTH-1:0] pull_dn_en
);

	initial
	begin
		if (WIDTH < 1)
			$error("pad count must be at least one");
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_pad
			// output data registered so the pad never glitches on func changes
			always_ff @(posedge clk_sys or posedge rst)
			begin
				if (rst)
					pad_o[i] <= 1'b0;
				else
					pad_o[i] <= drive_en ? func_out[i] : 1'b0;
			end
			// input with pull during reset, output after it
			assign pad_oe[i] = drive_en;
			assign pull_up_en[i] = ~drive_en & PULL_UP[i];
			assign pull_dn_en[i] = ~drive_en & ~PULL_UP[i];
		end
	endgenerate

endmodule

// ===== spl_strap_latch.sv
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "spl_regs.svh"

// Summary of operation
// - chip reset pin is active low
// - capture all straps at reset release
// - straps are pulled inputs, then outputs
// - three-bit management address from straps
// - default address one, upper bits zero
// - address zero broadcast unless strap or bit
// - mode 000 normal, 110 back-to-back, else reserved
// - wake strap loads control bit fifteen
// - speed strap loads speed bit and advertisement
// - duplex strap loads basic control bit eight
// - autoneg strap loads basic control bit twelve
// - low chain strap enables pin-chain test
module spl_strap_latch #(
	parameter int ADDR_W = 7
) (
	// clock and system reset
	input wire logic clk_sys,
	input wire logic rst,
	// chip reset pin, synchronous to clk_sys
	input wire logic chip_reset_n,
	// strap pads
	input wire spl_pkg::spl_straps_t strap_i,
	output logic [`SPL_NUM_STRAPS-1:0] strap_o,
	output logic [`SPL_NUM_STRAPS-1:0] strap_oe,
	output logic [`SPL_NUM_STRAPS-1:0] strap_pull_up,
	output logic [`SPL_NUM_STRAPS-1:0] strap_pull_dn,
	// functional values driven on the strap pads after reset
	input wire logic [`SPL_NUM_STRAPS-1:0] func_out,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// configuration to the rest of the transceiver
	output logic chip_in_reset,
	output logic config_valid,
	output logic [4:0] mgmt_address,
	output logic address_zero_broadcast,
	output spl_pkg::spl_if_mode_t if_mode,
	output logic wake_output_enable,
	output logic isolate_en,
	output logic speed_100,
	output logic duplex_ctrl,
	output logic autoneg_en,
	output logic [3:0] advert_abilities,
	output logic pin_chain_test_en
);

	initial
	begin
		if (ADDR_W < 7)
			$error("address must reach the strap status word");
	end

	// unstrapped pin levels, also the reset image of the loaded bits
	localparam logic [`SPL_NUM_STRAPS-1:0] STRAP_DEF = `SPL_STRAP_DEFAULT;

	// reset phase and release detection
	logic hold_q;
	logic release_pulse;
	logic drive_en;

	// captured straps
	logic [`SPL_NUM_STRAPS-1:0] cap_vec;
	logic cap_valid;
	spl_pkg::spl_straps_t cap;

	// software visible control bits
	logic bc_speed_q;
	logic bc_autoneg_q;
	logic bc_isolate_q;
	logic bc_duplex_q;
	logic [3:0] ad_abil_q;
	logic pc_wake_q;
	logic pc_addr0_unique_q;

	// bus sequencer
	spl_pkg::spl_bus_state_t bus_state_q;
	spl_pkg::spl_bus_state_t bus_state_d;
	logic [31:0] readdata_q;
	logic [31:0] rd_mux;
	logic [4:0] word_idx;
	logic word_aligned;
	logic [15:0] bc_word;
	logic [15:0] ad_word;
	logic [15:0] pc_word;
	logic [15:0] st_word;
	logic wr_commit;
	logic [15:0] wr_mask;
	logic [15:0] wr_data;

	// reset phase follows the pin; hold stays high while the pin is low
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			hold_q <= 1'b1;
		else
			hold_q <= ~chip_reset_n;
	end

	// release is the one edge where the pin is high after a held phase
	assign release_pulse = hold_q & chip_reset_n;
	assign drive_en = ~hold_q;
	assign chip_in_reset = hold_q;

	// holds the sampled pins until the next release
	spl_strap_capture #(
		.WIDTH(`SPL_NUM_STRAPS),
		.DEFAULT(`SPL_STRAP_DEFAULT)
	) u_capture (
		.clk_sys(clk_sys),
		.rst(rst),
		.release_pulse(release_pulse),
		.pins_in(strap_i),
		.captured(cap_vec),
		.valid(cap_valid)
	);

	assign cap = spl_pkg::spl_straps_t'(cap_vec);

	// pads take the pull during reset and serve outputs afterwards
	spl_pad_bank #(
		.WIDTH(`SPL_NUM_STRAPS),
		.PULL_UP(`SPL_STRAP_PULL_UP)
	) u_pads (
		.clk_sys(clk_sys),
		.rst(rst),
		.drive_en(drive_en),
		.func_out(func_out),
		.pad_o(strap_o),
		.pad_oe(strap_oe),
		.pull_up_en(strap_pull_up),
		.pull_dn_en(strap_pull_dn)
	);

	// address decode; only aligned word offsets hit a register
	assign word_idx = avs_address[6:2];
	assign word_aligned = (avs_address[1:0] == 2'h0);

	// lane merge for the 16-bit registers in the low half
	assign wr_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wr_data = avs_writedata[15:0];

	// a write lands only on the edge where waitrequest is low
	assign wr_commit = avs_write & (bus_state_q == spl_pkg::SPL_BUS_ANSWER) & word_aligned
		& ~hold_q;

	// basic control speed select, strap loaded then writable
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			bc_speed_q <= STRAP_DEF[`SPL_ST_SPEED];
		else if (release_pulse)
			bc_speed_q <= strap_i.speed;
		else if (wr_commit && word_idx == `SPL_IDX_BASIC_CTRL && wr_mask[`SPL_BC_SPEED])
			bc_speed_q <= wr_data[`SPL_BC_SPEED];
	end

	// basic control auto-negotiation enable
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			bc_autoneg_q <= STRAP_DEF[`SPL_ST_AUTONEG];
		else if (release_pulse)
			bc_autoneg_q <= strap_i.autoneg_enable_strap;
		else if (wr_commit && word_idx == `SPL_IDX_BASIC_CTRL && wr_mask[`SPL_BC_AUTONEG])
			bc_autoneg_q <= wr_data[`SPL_BC_AUTONEG];
	end

	// basic control isolate
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			bc_isolate_q <= STRAP_DEF[`SPL_ST_ISOLATE];
		else if (release_pulse)
			bc_isolate_q <= strap_i.isolate;
		else if (wr_commit && word_idx == `SPL_IDX_BASIC_CTRL && wr_mask[`SPL_BC_ISOLATE])
			bc_isolate_q <= wr_data[`SPL_BC_ISOLATE];
	end

	// basic control duplex; the pin level is stored as it stands
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			bc_duplex_q <= STRAP_DEF[`SPL_ST_DUPLEX];
		else if (release_pulse)
			bc_duplex_q <= strap_i.duplex;
		else if (wr_commit && word_idx == `SPL_IDX_BASIC_CTRL && wr_mask[`SPL_BC_DUPLEX])
			bc_duplex_q <= wr_data[`SPL_BC_DUPLEX];
	end

	// advertised abilities; a 10 Mbps strap withholds the 100 Mbps bits
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			ad_abil_q <= `SPL_AD_ABIL_100;
		else if (release_pulse)
			ad_abil_q <= strap_i.speed ? `SPL_AD_ABIL_100 : `SPL_AD_ABIL_10;
		else if (wr_commit && word_idx == `SPL_IDX_ADVERT)
		begin
			for (int b = 0; b < 4; b++)
			begin
				if (wr_mask[`SPL_AD_ABIL_LO + b])
					ad_abil_q[b] <= wr_data[`SPL_AD_ABIL_LO + b];
			end
		end
	end

	// wake output enable in the phy control word
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			pc_wake_q <= STRAP_DEF[`SPL_ST_WAKE];
		else if (release_pulse)
			pc_wake_q <= strap_i.wake_output_enable_strap;
		else if (wr_commit && word_idx == `SPL_IDX_PHY_CTRL && wr_mask[`SPL_PC_WAKE_EN])
			pc_wake_q <= wr_data[`SPL_PC_WAKE_EN];
	end

	// address zero unique bit; software may set it later without a strap
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			pc_addr0_unique_q <= STRAP_DEF[`SPL_ST_ADDR0_UNIQUE];
		else if (release_pulse)
			pc_addr0_unique_q <= strap_i.address_zero_unique_strap;
		else if (wr_commit && word_idx == `SPL_IDX_PHY_CTRL
			&& wr_mask[`SPL_PC_ADDR0_UNIQUE])
			pc_addr0_unique_q <= wr_data[`SPL_PC_ADDR0_UNIQUE];
	end

	// register images; unlisted bits read as zero
	always_comb
	begin
		bc_word = 16'h0000;
		bc_word[`SPL_BC_SPEED] = bc_speed_q;
		bc_word[`SPL_BC_AUTONEG] = bc_autoneg_q;
		bc_word[`SPL_BC_ISOLATE] = bc_isolate_q;
		bc_word[`SPL_BC_DUPLEX] = bc_duplex_q;
		ad_word = 16'h0000;
		ad_word[`SPL_AD_ABIL_HI:`SPL_AD_ABIL_LO] = ad_abil_q;
		ad_word[4:0] = `SPL_AD_SELECTOR;
		pc_word = 16'h0000;
		pc_word[`SPL_PC_WAKE_EN] = pc_wake_q;
		pc_word[`SPL_PC_ADDR0_UNIQUE] = pc_addr0_unique_q;
		st_word = 16'h0000;
		st_word[`SPL_NUM_STRAPS-1:0] = cap_vec;
		st_word[`SPL_ST_VALID] = cap_valid;
	end

	// read mux; unmapped or misaligned offsets read zero
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (word_aligned)
		begin
			case (word_idx)
				`SPL_IDX_BASIC_CTRL: rd_mux[15:0] = bc_word;
				`SPL_IDX_ADVERT: rd_mux[15:0] = ad_word;
				`SPL_IDX_PHY_CTRL: rd_mux[15:0] = pc_word;
				`SPL_IDX_STRAP_STAT: rd_mux[15:0] = st_word;
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// fixed one-cycle wait gives the read mux a full cycle to settle
	always_comb
	begin
		bus_state_d = bus_state_q;
		case (bus_state_q)
			spl_pkg::SPL_BUS_IDLE:
			begin
				if (avs_read || avs_write)
					bus_state_d = spl_pkg::SPL_BUS_ANSWER;
			end
			spl_pkg::SPL_BUS_ANSWER:
				bus_state_d = spl_pkg::SPL_BUS_IDLE;
			default:
				bus_state_d = spl_pkg::SPL_BUS_IDLE;
		endcase
	end

	// sequencer state
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			bus_state_q <= spl_pkg::SPL_BUS_IDLE;
		else
			bus_state_q <= bus_state_d;
	end

	// read data caught on the first cycle and held until the next read
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			readdata_q <= 32'h0000_0000;
		else if (avs_read && bus_state_q == spl_pkg::SPL_BUS_IDLE)
			readdata_q <= rd_mux;
	end

	assign avs_readdata = readdata_q;
	assign avs_waitrequest = (avs_read | avs_write) & (bus_state_q != spl_pkg::SPL_BUS_ANSWER);

	// management address, upper bits tied to zero
	assign mgmt_address = {`SPL_MGMT_UPPER, cap.mgmt_address_strap};

	// address zero answers as broadcast unless made unique
	assign address_zero_broadcast = ~pc_addr0_unique_q;

	// interface mode decode; reserved patterns are flagged, not remapped
	always_comb
	begin
		case (cap.mode)
			`SPL_MODE_NORMAL: if_mode = spl_pkg::SPL_IF_NORMAL;
			`SPL_MODE_B2B: if_mode = spl_pkg::SPL_IF_B2B;
			default: if_mode = spl_pkg::SPL_IF_RESERVED;
		endcase
	end

	// control outputs straight from the register bits
	assign wake_output_enable = pc_wake_q;
	assign isolate_en = bc_isolate_q;
	assign speed_100 = bc_speed_q;
	assign duplex_ctrl = bc_duplex_q;
	assign autoneg_en = bc_autoneg_q;
	assign advert_abilities = ad_abil_q;

	// chain test strap is active low and never software controlled
	assign pin_chain_test_en = cap_valid & ~cap.chain_test_n;

	assign config_valid = cap_valid & ~hold_q;

endmodule

// ===== spl_board_model.sv
`timescale 1ns/1ps

module spl_board_model (
	// clock and reset request
	input wire logic clk_sys,
	input wire logic hold_req,
	// board resistors
	input wire logic [12:0] ext_en,
	input wire logic [12:0] ext_val,
	// device pads
	input wire logic [12:0] strap_o,
	input wire logic [12:0] strap_oe,
	input wire logic [12:0] strap_pull_up,
	input wire logic [12:0] strap_pull_dn,
	output spl_pkg::spl_straps_t strap_i,
	output logic chip_reset_n
);
	logic [12:0] last_q;
	logic [12:0] pad;

	// reset source pulls the pin low while asked to hold
	assign chip_reset_n = !hold_req;

	// wired level: chip driver wins, then board resistor, then internal pull
	always_comb
	begin
		for (int i = 0; i < 13; i++)
		begin
			if (strap_oe[i])
				pad[i] = strap_o[i];
			else if (ext_en[i])
				pad[i] = ext_val[i];
			else if (strap_pull_up[i] || strap_pull_dn[i])
				pad[i] = strap_pull_up[i];
			else
				pad[i] = !last_q[i];
		end
	end
	assign strap_i = spl_pkg::spl_straps_t'(pad);

	// a floating pad must not look like a held level
	always_ff @(posedge clk_sys)
		last_q <= pad;
endmodule

// ===== spl_strap_latch_checker.sv
`timescale 1ns/1ps

module spl_strap_latch_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// reset pin and pads
	input wire logic chip_reset_n,
	input wire spl_pkg::spl_straps_t strap_i,
	input wire logic [12:0] strap_o,
	input wire logic [12:0] strap_oe,
	input wire logic [12:0] strap_pull_up,
	input wire logic [12:0] strap_pull_dn,
	input wire logic [12:0] func_out,
	// bus handshake
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	// configuration
	input wire logic chip_in_reset,
	input wire logic config_valid,
	input wire logic [4:0] mgmt_address,
	input wire logic address_zero_broadcast,
	input wire spl_pkg::spl_if_mode_t if_mode,
	input wire logic speed_100,
	input wire logic [3:0] advert_abilities,
	input wire logic pin_chain_test_en
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// expected mode decode, reserved for every other pattern
	function automatic spl_pkg::spl_if_mode_t mode_of(input logic [2:0] m);
		return m == 3'h0 ? spl_pkg::SPL_IF_NORMAL :
			m == 3'h6 ? spl_pkg::SPL_IF_B2B : spl_pkg::SPL_IF_RESERVED;
	endfunction

	// edge at which the straps are taken
	sequence release_edge;
		chip_in_reset && chip_reset_n;
	endsequence
	sequence req_start;
		$rose(avs_read || avs_write);
	endsequence

	chk_hold_track: assert property (!chip_reset_n |=> chip_in_reset)
		else $error("reset pin low but not held");
	chk_no_valid: assert property (chip_in_reset |-> !config_valid)
		else $error("config valid while held");
	chk_oe_phase: assert property (strap_oe == {13{!chip_in_reset}})
		else $error("pad enable off phase");
	chk_pull_on: assert property (chip_in_reset |->
		strap_pull_up == 13'h1701 && strap_pull_dn == 13'h08FE)
		else $error("pulls wrong while held");
	chk_pull_off: assert property (!chip_in_reset |->
		strap_pull_up == 13'h0000 && strap_pull_dn == 13'h0000)
		else $error("pulls on after release");
	chk_out_func: assert property (!chip_in_reset && !$past(chip_in_reset) |->
		strap_o == $past(func_out))
		else $error("pad data not functional");
	chk_load_addr: assert property (release_edge |-> ##2
		mgmt_address == {2'h0, $past(strap_i.mgmt_address_strap, 2)} &&
		address_zero_broadcast == !$past(strap_i.address_zero_unique_strap, 2))
		else $error("address load wrong");
	chk_load_mode: assert property (release_edge |-> ##2
		if_mode == mode_of($past(strap_i.mode, 2)) &&
		pin_chain_test_en == !$past(strap_i.chain_test_n, 2))
		else $error("mode or chain load wrong");
	chk_load_speed: assert property (release_edge |-> ##2
		speed_100 == $past(strap_i.speed, 2) &&
		advert_abilities == ($past(strap_i.speed, 2) ? 4'hF : 4'h3))
		else $error("speed load wrong");
	chk_caps_stable: assert property (
		!chip_in_reset && !$past(chip_in_reset) && !$past(chip_in_reset, 2) |->
		$stable(mgmt_address) && $stable(if_mode) && $stable(pin_chain_test_en))
		else $error("captured value moved");
	chk_bus_answer: assert property (req_start |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer timing wrong");
endmodule

bind spl_strap_latch spl_strap_latch_checker u_chk (.clk_sys, .rst, .chip_reset_n, .strap_i,
	.strap_o, .strap_oe, .strap_pull_up, .strap_pull_dn, .func_out, .avs_read, .avs_write,
	.avs_waitrequest, .chip_in_reset, .config_valid, .mgmt_address, .address_zero_broadcast,
	.if_mode, .speed_100, .advert_abilities, .pin_chain_test_en);

// ===== tb_top.sv
`timescale 1ns/1ps

module tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic hold_req = 1'b1;
	logic [12:0] ext_en = 13'h0000;
	logic [12:0] ext_val = 13'h0000;
	logic [12:0] func_out = 13'h0000;
	logic [6:0] avs_address = 7'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, chip_reset_n, chip_in_reset, config_valid, address_zero_broadcast;
	logic wake_output_enable, isolate_en, speed_100, duplex_ctrl, autoneg_en, pin_chain_test_en;
	logic [4:0] mgmt_address;
	logic [3:0] advert_abilities;
	logic [12:0] strap_o, strap_oe, strap_pull_up, strap_pull_dn;
	spl_pkg::spl_straps_t strap_i;
	spl_pkg::spl_if_mode_t if_mode;
	int fail_count = 0;
	int n_checks = 0;

	// 100 MHz system clock
	always #5 clk_sys = !clk_sys;

	spl_board_model board (.clk_sys, .hold_req, .ext_en, .ext_val, .strap_o, .strap_oe,
		.strap_pull_up, .strap_pull_dn, .strap_i, .chip_reset_n);
	spl_strap_latch DUT (.clk_sys, .rst, .chip_reset_n, .strap_i, .strap_o, .strap_oe,
		.strap_pull_up, .strap_pull_dn, .func_out, .avs_address, .avs_read, .avs_write,
		.avs_byteenable(4'hF), .avs_writedata, .avs_readdata, .avs_waitrequest,
		.chip_in_reset, .config_valid, .mgmt_address, .address_zero_broadcast, .if_mode,
		.wake_output_enable, .isolate_en, .speed_100, .duplex_ctrl, .autoneg_en,
		.advert_abilities, .pin_chain_test_en);

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one bus request, held until waitrequest is seen low; bounded wait
	task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		// waitrequest and read data are taken as they stand at each rising edge
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0)
		begin
			n++;
			if (n > 20)
			begin
				fail_count++;
				finish_test();
			end
			@(posedge clk_sys);
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	// pulse the chip reset pin with the board strapped as given
	task automatic chip_reset(input logic [12:0] en, input logic [12:0] val);
		@(posedge clk_sys);
		ext_en <= en;
		ext_val <= val;
		hold_req <= 1'b1;
		repeat (3) @(negedge clk_sys);
		chk(strap_oe, 13'h0000);
		chk(strap_pull_up, 13'h1701);
		chk(chip_in_reset, 1'b1);
		@(posedge clk_sys);
		hold_req <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask

	// outputs and readback expected after capturing s
	task automatic check_cfg(input logic [12:0] s);
		logic [31:0] q;
		logic [3:0] ab;
		ab = s[8] ? 4'hF : 4'h3;
		@(negedge clk_sys);
		chk(mgmt_address, {2'h0, s[2:0]});
		chk(if_mode, s[5:3] == 3'h0 ? spl_pkg::SPL_IF_NORMAL :
			s[5:3] == 3'h6 ? spl_pkg::SPL_IF_B2B : spl_pkg::SPL_IF_RESERVED);
		chk(address_zero_broadcast, !s[11]);
		chk(wake_output_enable, s[6]);
		chk(isolate_en, s[7]);
		chk(speed_100, s[8]);
		chk(advert_abilities, ab);
		chk(duplex_ctrl, s[9]);
		chk(autoneg_en, s[10]);
		chk(pin_chain_test_en, !s[12]);
		chk(config_valid, 1'b1);
		bus(1'b0, 7'h7C, 32'h0, q);
		chk(q, {16'h0, 3'h4, s});
		bus(1'b0, 7'h00, 32'h0, q);
		chk(q, {18'h0, s[8], s[10], 1'b0, s[7], 1'b0, s[9], 8'h00});
		bus(1'b0, 7'h10, 32'h0, q);
		chk(q, {23'h0, ab, 5'h01});
		bus(1'b0, 7'h58, 32'h0, q);
		chk(q, {16'h0, s[6], 5'h00, s[11], 9'h000});
	endtask

	// unstrapped board: internal pulls alone decide
	task automatic test_default();
		chip_reset(13'h0000, 13'h0000);
		check_cfg(13'h1701);
		$display("test_default done");
	endtask

	// boards strapped away from the defaults, every mode class
	task automatic test_strapped();
		logic [12:0] tbl [4] = '{13'h08F7, 13'h1710, 13'h1FFF, 13'h0000};
		foreach (tbl[i])
		begin
			chip_reset(13'h1FFF, tbl[i]);
			check_cfg(tbl[i]);
		end
		$display("test_strapped done");
	endtask

	// software overrides loaded bits; status and selector refuse writes
	task automatic test_write();
		logic [31:0] q;
		chip_reset(13'h0000, 13'h0000);
		bus(1'b1, 7'h00, 32'h0000_0500, q);
		bus(1'b1, 7'h58, 32'h0000_8200, q);
		bus(1'b1, 7'h7C, 32'h0000_0000, q);
		bus(1'b1, 7'h10, 32'h0000_0000, q);
		@(negedge clk_sys);
		chk({speed_100, autoneg_en, isolate_en, duplex_ctrl}, 4'h3);
		chk({wake_output_enable, address_zero_broadcast}, 2'h2);
		chk(advert_abilities, 4'h0);
		bus(1'b0, 7'h7C, 32'h0, q);
		chk(q, 32'h0000_9701);
		bus(1'b0, 7'h40, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b0, 7'h10, 32'h0, q);
		chk(q, 32'h1);
		$display("test_write done");
	endtask

	// pads turn to outputs; their new levels never reach the captures
	task automatic test_pads();
		chip_reset(13'h1FFF, 13'h08F7);
		func_out <= 13'h0ABC;
		repeat (2) @(negedge clk_sys);
		chk(strap_o, 13'h0ABC);
		chk(strap_oe, 13'h1FFF);
		check_cfg(13'h08F7);
		$display("test_pads done");
	endtask

	// main sequence
	initial
	begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		test_default();
		test_strapped();
		test_write();
		test_pads();
		finish_test();
	end
endmodule
